// *** design/ioc_map.svh ***
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH

// register byte offsets
`define IOC_CTRL_OFS      32'h0000_0000
`define IOC_SWITCH_OFS    32'h0000_0004
`define IOC_STATUS_OFS    32'h0000_0008

// control register fields
`define IOC_P5_FUNC_LSB   0
`define IOC_P5_LATCH_BIT  2
`define IOC_P5_INV_BIT    3
`define IOC_P5_OSEL_LSB   4
`define IOC_P6_FUNC_LSB   8
`define IOC_P6_INV_BIT    11
`define IOC_P6_OSEL_LSB   12
`define IOC_CTRL_RST      32'h0000_0000
`define IOC_CTRL_MASK     32'h0000_3b3f

// switch register write bits
`define IOC_SW_ON_BIT     0
`define IOC_SW_OFF_BIT    1

// status register bits
`define IOC_ST_SW_BIT     0
`define IOC_ST_PWR_BIT    1
`define IOC_ST_SUPP_BIT   2
`define IOC_ST_PROT_BIT   3
`define IOC_ST_P5_BIT     4
`define IOC_ST_P6_BIT     5

// pin function and output value codes
`define IOC_FN_SPECIAL    2'h0
`define IOC_FN_INPUT      2'h1
`define IOC_FN_OUTPUT     2'h2
`define IOC_OV_FALSE      2'h0
`define IOC_OV_TRUE       2'h1
`define IOC_OV_PWM        2'h2

// bus responses
`define IOC_RESP_OKAY     2'h0
`define IOC_RESP_SLVERR   2'h2

// timing
`define IOC_CLK_PERIOD_NS 25
`define IOC_MIN_LOW_NS    30000
`define IOC_CNT_W         11
`define IOC_MIN_LOW_CYC   ((`IOC_MIN_LOW_NS + `IOC_CLK_PERIOD_NS - 1) / `IOC_CLK_PERIOD_NS)

`endif

// *** design/ioc_pkg.sv ***
`include "ioc_map.svh"

package ioc_pkg;

  typedef enum logic [1:0] {
    IOC_EM_IDLE  = 2'b01,
    IOC_EM_PULSE = 2'b10
  } ioc_emit_t;

  typedef struct packed {
    logic                   p5_s1;
    logic                   p5_s2;
    logic                   p6_s1;
    logic                   p6_s2;
    logic [`IOC_CNT_W-1:0]  p5_cnt;
    logic [`IOC_CNT_W-1:0]  p6_cnt;
    logic [`IOC_CNT_W-1:0]  em_cnt;
    ioc_emit_t              em;
    logic                   sw;
    logic                   pwr;
    logic                   supp;
    logic                   prot;
    logic                   p5_o;
    logic                   p5_oe;
    logic                   p6_o;
    logic                   p6_oe;
    logic [31:0]            ctrl;
    logic                   aw_got;
    logic                   w_got;
    logic [31:0]            aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } ioc_state_t;

endpackage

// *** design/ioc_pins.sv ***
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ioc_map.svh"
module ioc_pins (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pin5_i,
  output logic             pin5_o,
  output logic             pin5_oe,
  input  wire logic        pin6_i,
  output logic             pin6_o,
  output logic             pin6_oe,
  input  wire logic        pwm_in,
  output logic             output_switch,
  output logic             power_enable,
  output logic             output_suppressed_flag,
  output logic             latched_protect_flag
);

  localparam logic [`IOC_CNT_W-1:0] MIN_CYC = `IOC_CNT_W'(`IOC_MIN_LOW_CYC);

  ioc_pkg::ioc_state_t q;
  ioc_pkg::ioc_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // one-hot register select: {status, switch, ctrl}, zero when unmapped
  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    logic [2:0] s;
    s = 3'h0;
    if (a == `IOC_CTRL_OFS)   s = 3'h1;
    if (a == `IOC_SWITCH_OFS) s = 3'h2;
    if (a == `IOC_STATUS_OFS) s = 3'h4;
    return s;
  endfunction

  // low-phase width counter, saturating at the minimum width
  function automatic logic [`IOC_CNT_W-1:0] cnt_step(input logic [`IOC_CNT_W-1:0] c,
                                                     input logic act);
    logic [`IOC_CNT_W-1:0] n;
    n = '0;
    if (act) begin
      n = (c == MIN_CYC) ? c : c + `IOC_CNT_W'(1);
    end
    return n;
  endfunction

  // pin level for output mode: logic one is a low pin, inversion swaps
  function automatic logic out_level(input logic [1:0] sel, input logic pwm,
                                     input logic inv);
    logic v;
    v = 1'b0;
    case (sel)
      `IOC_OV_TRUE: v = 1'b1;
      `IOC_OV_PWM:  v = pwm;
      default:      v = 1'b0;
    endcase
    return ~v ^ inv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control fields

  logic [1:0] p5_func;
  logic       p5_latch;
  logic       p5_inv;
  logic [1:0] p5_osel;
  logic [1:0] p6_func;
  logic       p6_inv;
  logic [1:0] p6_osel;

  assign p5_func  = q.ctrl[`IOC_P5_FUNC_LSB +: 2];
  assign p5_latch = q.ctrl[`IOC_P5_LATCH_BIT];
  assign p5_inv   = q.ctrl[`IOC_P5_INV_BIT];
  assign p5_osel  = q.ctrl[`IOC_P5_OSEL_LSB +: 2];
  assign p6_func  = q.ctrl[`IOC_P6_FUNC_LSB +: 2];
  assign p6_inv   = q.ctrl[`IOC_P6_INV_BIT];
  assign p6_osel  = q.ctrl[`IOC_P6_OSEL_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // pin sensing

  logic lvl5;
  logic lvl6;
  logic act5;
  logic act6;
  logic qual5;
  logic qual6;
  logic lvl_inh;

  assign lvl5    = q.p5_s2 ^ p5_inv;
  assign lvl6    = q.p6_s2 ^ p6_inv;
  assign act5    = !lvl5 && (p5_func == `IOC_FN_SPECIAL) && p5_latch;
  assign act6    = !lvl6 && (p6_func == `IOC_FN_SPECIAL) && (q.em == ioc_pkg::IOC_EM_IDLE);
  assign qual5   = act5 && (q.p5_cnt == MIN_CYC - `IOC_CNT_W'(1));
  assign qual6   = act6 && (q.p6_cnt == MIN_CYC - `IOC_CNT_W'(1));
  assign lvl_inh = (p5_func == `IOC_FN_SPECIAL) && !p5_latch && !lvl5;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes

  logic [2:0] wsel;
  logic [2:0] rsel;
  logic       wr_fire;
  logic [31:0] wmask;
  logic       sw_on_wr;
  logic       sw_off_wr;
  logic       prot_clr;
  logic       trip;
  logic       sync_on;
  logic       sw_n;

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign wsel          = reg_sel(q.aw_addr);
  assign rsel          = reg_sel(s_axi_araddr);
  assign wr_fire       = q.aw_got && q.w_got && !q.bvalid;
  assign wmask         = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}},
                          {8{q.w_strb[0]}}};
  assign sw_on_wr      = wr_fire && wsel[1] && q.w_strb[0] && q.w_data[`IOC_SW_ON_BIT];
  assign sw_off_wr     = wr_fire && wsel[1] && q.w_strb[0] && q.w_data[`IOC_SW_OFF_BIT];
  assign prot_clr      = wr_fire && wsel[2] && q.w_strb[0] && q.w_data[`IOC_ST_PROT_BIT];
  assign trip          = qual5 && q.sw;
  assign sync_on       = qual6 && !q.sw && !q.prot;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    sw_n = q.sw;

    // two-stage synchronisers
    d.p5_s1 = pin5_i;
    d.p5_s2 = q.p5_s1;
    d.p6_s1 = pin6_i;
    d.p6_s2 = q.p6_s1;
    d.p5_cnt = cnt_step(q.p5_cnt, act5);
    d.p6_cnt = cnt_step(q.p6_cnt, act6);

    // output switch: off requests and trips win over on requests
    if (sw_on_wr && !q.prot) begin
      sw_n = 1'b1;
    end
    if (sync_on) begin
      sw_n = 1'b1;
    end
    if (sw_off_wr || trip) begin
      sw_n = 1'b0;
    end
    d.sw   = sw_n;
    d.pwr  = sw_n && !lvl_inh;
    d.supp = lvl_inh;
    d.prot = (q.prot && !prot_clr) || trip;

    // turn-on pulse emitter
    case (q.em)
      ioc_pkg::IOC_EM_IDLE: begin
        if ((p6_func == `IOC_FN_SPECIAL) && sw_n && !q.sw) begin
          d.em     = ioc_pkg::IOC_EM_PULSE;
          d.em_cnt = '0;
        end
      end
      ioc_pkg::IOC_EM_PULSE: begin
        if (q.em_cnt == MIN_CYC - `IOC_CNT_W'(1)) begin
          d.em = ioc_pkg::IOC_EM_IDLE;
        end else begin
          d.em_cnt = q.em_cnt + `IOC_CNT_W'(1);
        end
      end
      default: begin
        d.em = ioc_pkg::IOC_EM_IDLE;
      end
    endcase

    // pin drivers
    d.p5_oe = (p5_func == `IOC_FN_OUTPUT);
    d.p5_o  = (p5_func == `IOC_FN_OUTPUT) ? out_level(p5_osel, pwm_in, p5_inv) : 1'b0;
    if (p6_func == `IOC_FN_OUTPUT) begin
      d.p6_oe = 1'b1;
      d.p6_o  = out_level(p6_osel, pwm_in, p6_inv);
    end else if (p6_func == `IOC_FN_SPECIAL) begin
      d.p6_oe = (d.em == ioc_pkg::IOC_EM_PULSE);
      d.p6_o  = p6_inv;
    end else begin
      d.p6_oe = 1'b0;
      d.p6_o  = 1'b0;
    end

    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = (wsel == 3'h0) ? `IOC_RESP_SLVERR : `IOC_RESP_OKAY;
      if (wsel[0]) begin
        d.ctrl = ((q.ctrl & ~wmask) | (q.w_data & wmask)) & `IOC_CTRL_MASK;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = (rsel == 3'h0) ? `IOC_RESP_SLVERR : `IOC_RESP_OKAY;
      d.rdata  = 32'h0;
      if (rsel[0]) begin
        d.rdata = q.ctrl;
      end
      if (rsel[1]) begin
        d.rdata[`IOC_ST_SW_BIT] = q.sw;
      end
      if (rsel[2]) begin
        d.rdata[`IOC_ST_SW_BIT]   = q.sw;
        d.rdata[`IOC_ST_PWR_BIT]  = q.pwr;
        d.rdata[`IOC_ST_SUPP_BIT] = q.supp;
        d.rdata[`IOC_ST_PROT_BIT] = q.prot;
        d.rdata[`IOC_ST_P5_BIT]   = q.p5_s2;
        d.rdata[`IOC_ST_P6_BIT]   = q.p6_s2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q       <= '0;
      // synchronisers start at the pulled-up idle level: no false low after reset
      q.p5_s1 <= 1'b1;
      q.p5_s2 <= 1'b1;
      q.p6_s1 <= 1'b1;
      q.p6_s2 <= 1'b1;
      q.em    <= ioc_pkg::IOC_EM_IDLE;
      q.ctrl  <= `IOC_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_bresp            = q.bresp;
  assign s_axi_bvalid           = q.bvalid;
  assign s_axi_rdata            = q.rdata;
  assign s_axi_rresp            = q.rresp;
  assign s_axi_rvalid           = q.rvalid;
  assign pin5_o                 = q.p5_o;
  assign pin5_oe                = q.p5_oe;
  assign pin6_o                 = q.p6_o;
  assign pin6_oe                = q.p6_oe;
  assign output_switch          = q.sw;
  assign power_enable           = q.pwr;
  assign output_suppressed_flag = q.supp;
  assign latched_protect_flag   = q.prot;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_level_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lvl_inh && q.sw && !sw_off_wr && !trip |=> q.sw && !power_enable
  ) else $error("level inhibit did not gate power");

  a_level_restore: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !lvl_inh && q.sw && !sw_off_wr && !trip |=> power_enable
  ) else $error("power not restored after level inhibit");

  a_supp_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lvl_inh |=> output_suppressed_flag
  ) else $error("suppressed flag missing");

  a_latch_trip: assert property (
    @(posedge aclk) disable iff (!aresetn)
    qual5 && q.sw |=> !output_switch && latched_protect_flag && !power_enable
  ) else $error("latched pulse did not trip the switch");

  a_protect_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    latched_protect_flag && !prot_clr |=> latched_protect_flag && !$rose(output_switch)
  ) else $error("protect flag or switch released without clear");

  a_qual_width: assert property (
    @(posedge aclk) disable iff (!aresetn)
    qual5 |-> $past(act5, 8) && q.p5_cnt == MIN_CYC - `IOC_CNT_W'(1)
  ) else $error("pulse qualified before minimum width");

  a_sync_ignore: assert property (
    @(posedge aclk) disable iff (!aresetn)
    qual6 && q.sw && !sw_off_wr && !trip |=> output_switch
  ) else $error("sync pulse disturbed an on switch");

  a_sync_turn_on: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sync_on && !sw_off_wr && !trip |=> output_switch
  ) else $error("sync pulse did not turn the switch on");

  a_sync_emit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(output_switch) && p6_func == `IOC_FN_SPECIAL && $past(q.em) == ioc_pkg::IOC_EM_IDLE
    |-> pin6_oe && pin6_o == p6_inv ##1 pin6_oe [*8]
  ) else $error("turn-on pulse not emitted");

  a_out_drive: assert property (
    @(posedge aclk) disable iff (!aresetn)
    p5_func == `IOC_FN_OUTPUT && p5_osel == `IOC_OV_TRUE && $stable(q.ctrl)
    |=> pin5_oe && pin5_o == $past(p5_inv)
  ) else $error("output mode drives the wrong level");

endmodule

// *** bench/ioc_pin_src.sv ***
`timescale 1ns/100ps
module ioc_pin_src (
  input  wire logic aclk,
  input  wire logic pin5_o,
  input  wire logic pin5_oe,
  input  wire logic pin6_o,
  input  wire logic pin6_oe,
  output wire logic pin5_i,
  output wire logic pin6_i
);
  logic lo5_q;
  logic lo6_q;

  initial begin
    lo5_q = 1'b0;
    lo6_q = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulled-up open lines: a released line reads high, any low driver wins
  assign pin5_i = (pin5_oe ? pin5_o : 1'b1) & ~lo5_q;
  assign pin6_i = (pin6_oe ? pin6_o : 1'b1) & ~lo6_q;

  ////////////////////////////////////////////////////////////////////////////////
  // pull a pin low or release it, just after a clock edge
  task automatic drive(input int pin, input logic lo);
    @(posedge aclk);
    if (pin == 5) begin
      lo5_q <= lo;
    end else begin
      lo6_q <= lo;
    end
  endtask

  // low phase held for one cycle more than the requested number of cycles
  task automatic pulse(input int pin, input int cyc);
    drive(pin, 1'b1);
    repeat (cyc) @(posedge aclk);
    drive(pin, 1'b0);
  endtask
endmodule

// *** bench/inhibit_and_sync_on_io_pins_tb.sv ***
`timescale 1ns/100ps
`include "ioc_map.svh"
module inhibit_and_sync_on_io_pins_tb;
  logic        aclk;
  logic        aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pwm_in;
  logic        pin5_i, pin5_o, pin5_oe, pin6_i, pin6_o, pin6_oe;
  logic        output_switch, power_enable, output_suppressed_flag, latched_protect_flag;
  logic [31:0] oc [4] = '{32'h1212, 32'h1a1a, 32'h0202, 32'h0a0a};
  logic [3:0]  oe [4] = '{4'ha, 4'hf, 4'hf, 4'ha};
  int          errors;
  int          n_tests;
  int          i;
  wire logic [3:0] st = {output_switch, power_enable, output_suppressed_flag,
                         latched_protect_flag};

  ioc_pins u_ioc_pins (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin5_i, .pin5_o,
    .pin5_oe, .pin6_i, .pin6_o, .pin6_oe, .pwm_in, .output_switch, .power_enable,
    .output_suppressed_flag, .latched_protect_flag
  );

  ioc_pin_src u_ioc_pin_src (
    .aclk, .pin5_o, .pin5_oe, .pin6_o, .pin6_oe, .pin5_i, .pin6_i
  );

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tmo;
    errors++;
    $display("mismatch at %0t: timeout", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // one write: address and data offered together, held until each is taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int k = 0; k <= 64; k++) begin
      if (k == 64) tmo();
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp_q = s_axi_bresp;
        break;
      end
    end
  endtask

  task automatic rd(input logic [31:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int k = 0; k <= 64; k++) begin
      if (k == 64) tmo();
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_q   = s_axi_rdata;
        resp_q = s_axi_rresp;
        break;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge aclk);
    tmo();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pwm_in} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    // registers and bus
    rd(`IOC_CTRL_OFS);
    chk(rd_q, `IOC_CTRL_RST);
    rd(`IOC_STATUS_OFS);
    chk(rd_q, 32'h30);
    wr(`IOC_CTRL_OFS, 32'hffff_ffff);
    chk({30'h0, resp_q}, {30'h0, `IOC_RESP_OKAY});
    rd(`IOC_CTRL_OFS);
    chk(rd_q, `IOC_CTRL_MASK);
    rd(32'h10);
    chk({30'h0, resp_q}, {30'h0, `IOC_RESP_SLVERR});
    chk(rd_q, 32'h0);
    wr(32'h10, 32'h1);
    chk({30'h0, resp_q}, {30'h0, `IOC_RESP_SLVERR});
    $display("test bus done");
    // level inhibit
    wr(`IOC_CTRL_OFS, 32'h0);
    wr(`IOC_SWITCH_OFS, 32'h1);
    cyc(4);
    chk({28'h0, st}, 32'hc);
    u_ioc_pin_src.drive(5, 1'b1);
    cyc(6);
    chk({28'h0, st}, 32'ha);
    u_ioc_pin_src.drive(5, 1'b0);
    cyc(6);
    chk({28'h0, st}, 32'hc);
    wr(`IOC_CTRL_OFS, 32'h8);
    cyc(6);
    chk({28'h0, st}, 32'ha);
    u_ioc_pin_src.drive(5, 1'b1);
    cyc(6);
    chk({28'h0, st}, 32'hc);
    u_ioc_pin_src.drive(5, 1'b0);
    $display("test level inhibit done");
    // latched inhibit
    wr(`IOC_CTRL_OFS, 32'h4);
    cyc(6);
    chk({28'h0, st}, 32'hc);
    u_ioc_pin_src.pulse(5, 100);
    cyc(6);
    chk({28'h0, st}, 32'hc);
    u_ioc_pin_src.pulse(5, 1300);
    cyc(6);
    chk({28'h0, st}, 32'h1);
    wr(`IOC_SWITCH_OFS, 32'h1);
    cyc(4);
    chk({28'h0, st}, 32'h1);
    wr(`IOC_STATUS_OFS, 32'h8);
    cyc(4);
    chk({28'h0, st}, 32'h0);
    wr(`IOC_SWITCH_OFS, 32'h1);
    cyc(4);
    chk({28'h0, st}, 32'hc);
    $display("test latched inhibit done");
    // synchronised turn-on
    wr(`IOC_CTRL_OFS, 32'h0);
    wr(`IOC_SWITCH_OFS, 32'h2);
    cyc(1250);
    chk({28'h0, st}, 32'h0);
    u_ioc_pin_src.pulse(6, 1300);
    cyc(4);
    chk({28'h0, st}, 32'hc);
    cyc(1250);
    u_ioc_pin_src.pulse(6, 1300);
    cyc(4);
    chk({28'h0, st}, 32'hc);
    wr(`IOC_SWITCH_OFS, 32'h2);
    cyc(4);
    wr(`IOC_SWITCH_OFS, 32'h1);
    cyc(1);
    chk({30'h0, pin6_oe, pin6_o}, 32'h2);
    cyc(1190);
    chk({31'h0, pin6_oe}, 32'h1);
    cyc(20);
    chk({31'h0, pin6_oe}, 32'h0);
    $display("test sync turn-on done");
    // output and input modes
    for (i = 0; i < 4; i++) begin
      wr(`IOC_CTRL_OFS, oc[i]);
      cyc(4);
      chk({28'h0, pin5_oe, pin5_o, pin6_oe, pin6_o}, {28'h0, oe[i]});
    end
    // both pins in output mode selecting the pwm level
    pwm_in <= 1'b1;
    wr(`IOC_CTRL_OFS, 32'h2222);
    cyc(4);
    chk({28'h0, pin5_oe, pin5_o, pin6_oe, pin6_o}, 32'ha);
    pwm_in <= 1'b0;
    cyc(4);
    chk({28'h0, pin5_oe, pin5_o, pin6_oe, pin6_o}, 32'hf);
    wr(`IOC_CTRL_OFS, 32'h0101);
    u_ioc_pin_src.drive(5, 1'b1);
    cyc(6);
    rd(`IOC_STATUS_OFS);
    chk({pin5_oe, pin6_oe, rd_q[5:4], st}, 10'h2c);
    u_ioc_pin_src.drive(5, 1'b0);
    $display("test pin modes done");
    wrap_up();
  end
endmodule
